// ==== hdl/evt_pkg.sv ====
// constants for the eight bit interval event timer
package evt_pkg;
  localparam logic [15:0] EVT_ADDR_PORT2_DIR = 16'hFF22;
  localparam logic [15:0] EVT_ADDR_MODE_CTRL = 16'hFF53;
  localparam logic [15:0] EVT_ADDR_COUNT = 16'hFF54;
  localparam logic [15:0] EVT_ADDR_COMPARE = 16'hFF55;
  localparam logic [7:0] EVT_MODE_RESET = 8'h00;
  localparam logic [7:0] EVT_DIR_RESET = 8'hFF;
  localparam logic [7:0] EVT_MODE_WMASK = 8'hC7;
  localparam int EVT_BIT_RUN = 7;
  localparam int EVT_BIT_PWM = 6;
  localparam int EVT_BIT_CLK_HI = 2;
  localparam int EVT_BIT_CLK_LO = 1;
  localparam int EVT_BIT_OUT_EN = 0;
  localparam int EVT_SHARED_PIN = 7;
  localparam int EVT_PRESCALE = 256;
  typedef enum logic [1:0] {
    EVT_CLK_SYS = 2'b00,
    EVT_CLK_DIV = 2'b01,
    EVT_CLK_RISE = 2'b10,
    EVT_CLK_FALL = 2'b11
  } evt_clk_sel_t;
endpackage

// ==== hdl/evt_timer.sv ====
// eight bit interval and event timer with port 2 direction control
module evt_timer
  import evt_pkg::*;
#(
  parameter int PRESCALE = EVT_PRESCALE
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [7:0] port2_latch,
  input wire logic [7:0] port2_pin_in,
  output logic [7:0] port2_pin_out,
  output logic [7:0] port2_pin_oe,
  output logic match_irq
);
  localparam int PW = $clog2(PRESCALE);

  initial
  begin
    if (PRESCALE < 2 || (1 << PW) != PRESCALE)
      $error("prescale must be a power of two of at least two");
    if (EVT_SHARED_PIN > 7)
      $error("shared pin index out of range");
  end

  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] cmp_reg;
  logic [7:0] cmp_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic sync1_reg;
  logic sync2_reg;
  logic evt_prev_reg;
  logic evt_prev_next;
  logic tout_reg;
  logic tout_next;
  logic irq_reg;
  logic irq_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] pout_reg;
  logic [7:0] pout_next;
  logic [7:0] poe_reg;
  logic [7:0] poe_next;
  logic run;
  logic pwm;
  logic ext_clk;
  logic tick;
  logic match;
  evt_clk_sel_t csel;

  // mode register; unused bits are never stored
  always_comb
  begin
    mode_next = mode_reg;
    if (wr_en && addr == EVT_ADDR_MODE_CTRL)
    begin
      if (bit_wr)
        mode_next[bit_sel] = wdata[0];
      else
        mode_next = wdata;
      mode_next = mode_next & EVT_MODE_WMASK;
    end
  end

  // direction register
  always_comb
  begin
    dir_next = dir_reg;
    if (wr_en && addr == EVT_ADDR_PORT2_DIR)
    begin
      if (bit_wr)
        dir_next[bit_sel] = wdata[0];
      else
        dir_next = wdata;
    end
  end

  // compare register; bit writes ignored, byte only
  always_comb
  begin
    cmp_next = cmp_reg;
    if (wr_en && !bit_wr && addr == EVT_ADDR_COMPARE)
      cmp_next = wdata;
  end

  assign run = mode_reg[EVT_BIT_RUN];
  assign pwm = mode_reg[EVT_BIT_PWM];
  assign csel = evt_clk_sel_t'({mode_reg[EVT_BIT_CLK_HI], mode_reg[EVT_BIT_CLK_LO]});
  assign ext_clk = (csel == EVT_CLK_RISE) || (csel == EVT_CLK_FALL);

  // prescaler cleared while stopped, so a start sees a full first period
  always_comb
  begin
    pre_next = run ? PW'(pre_reg + 1'b1) : '0;
  end

  // pin edges seen only after the two-stage synchroniser
  always_comb
  begin
    evt_prev_next = sync2_reg;
    case (csel)
      EVT_CLK_SYS: tick = 1'b1;
      EVT_CLK_DIV: tick = (pre_reg == {PW{1'b1}});
      EVT_CLK_RISE: tick = sync2_reg && !evt_prev_reg;
      EVT_CLK_FALL: tick = !sync2_reg && evt_prev_reg;
      default: tick = 1'b0;
    endcase
  end

  // counter, compare and output waveform
  always_comb
  begin
    match = run && tick && (cnt_reg == cmp_reg);
    cnt_next = cnt_reg;
    tout_next = tout_reg;
    irq_next = 1'b0;
    if (!run)
    begin
      cnt_next = '0;
      tout_next = 1'b0;
    end
    else if (tick)
    begin
      if (pwm)
      begin
        // pwm: free-running 8 bit period, high from the wrap to 00 until match
        cnt_next = cnt_reg + 8'h01;
        irq_next = match;
        if (cnt_reg == 8'hFF)
          tout_next = 1'b1;
        else if (match)
          tout_next = 1'b0;
      end
      else if (match)
      begin
        cnt_next = '0;
        irq_next = 1'b1;
        tout_next = !tout_reg;
      end
      else
        cnt_next = cnt_reg + 8'h01;
    end
  end

  // pin drive per pin; timer output only when enabled and not clocking from the pin
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    assign poe_next[i] = !dir_reg[i];
    if (i == EVT_SHARED_PIN)
    begin : g_shared
      assign pout_next[i] = port2_latch[i] |
        (tout_reg & mode_reg[EVT_BIT_OUT_EN] & !ext_clk);
    end
    else
    begin : g_plain
      assign pout_next[i] = port2_latch[i];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_en)
    begin
      case (addr)
        EVT_ADDR_MODE_CTRL: rdata_next = mode_reg;
        EVT_ADDR_PORT2_DIR: rdata_next = dir_reg;
        EVT_ADDR_COUNT: rdata_next = cnt_reg;
        EVT_ADDR_COMPARE: rdata_next = cmp_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= EVT_MODE_RESET;
      dir_reg <= EVT_DIR_RESET;
    end
    else
    begin
      mode_reg <= mode_next;
      dir_reg <= dir_next;
    end
  end

  // prescaler
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg <= '0;
    end
    else
    begin
      pre_reg <= pre_next;
    end
  end

  // pin synchroniser and edge history; only the second stage is read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      evt_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= port2_pin_in[EVT_SHARED_PIN];
      sync2_reg <= sync1_reg;
      evt_prev_reg <= evt_prev_next;
    end
  end

  // counter, output waveform and match pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 8'h00;
      tout_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tout_reg <= tout_next;
      irq_reg <= irq_next;
    end
  end

  // pin drivers, registered so the pins never glitch
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pout_reg <= 8'h00;
      poe_reg <= 8'h00;
    end
    else
    begin
      pout_reg <= pout_next;
      poe_reg <= poe_next;
    end
  end

  // read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // compare value has no reset, as it is undefined after reset
  always_ff @(posedge clk)
  begin
    cmp_reg <= cmp_next;
  end

  assign rdata = rdata_reg;
  assign port2_pin_out = pout_reg;
  assign port2_pin_oe = poe_reg;
  assign match_irq = irq_reg;
endmodule

// ==== tb/evt_pin_model.sv ====
// event source on the shared port pins
module evt_pin_model (
  input wire logic clk,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_reg = 3'h0;
  // bit 7 is the event input, one edge of each kind per 8 clocks
  // unused bits wander so a stale level never looks valid
  assign pin = {cnt_reg[2], cnt_reg, {4{cnt_reg[0]}} ^ 4'h5};
  always @(posedge clk)
    cnt_reg <= cnt_reg + 3'h1;
endmodule

// ==== tb/evt_timer_assertions.sv ====
// port checker for the interval event timer
module evt_timer_assertions
  import evt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic [7:0] port2_latch,
  input wire logic [7:0] port2_pin_out,
  input wire logic [7:0] port2_pin_oe,
  input wire logic match_irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic mw = wr_en && !bit_wr && addr == EVT_ADDR_MODE_CTRL;
  wire logic mr = rd_en && addr == EVT_ADDR_MODE_CTRL;
  wire logic dw = wr_en && addr == EVT_ADDR_PORT2_DIR;
  logic [7:0] mode_exp;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_exp <= EVT_MODE_RESET;
    else if (mw)
      mode_exp <= wdata & EVT_MODE_WMASK;
    else if (wr_en && bit_wr && addr == EVT_ADDR_MODE_CTRL)
      mode_exp[bit_sel] <= wdata[0] & EVT_MODE_WMASK[bit_sel];
  end
  a_mode_readback: assert property (
    mr |=> rdata == $past(mode_exp)) else $error("mode readback");
  a_mode_zero: assert property (mr |=> rdata[5:3] == 3'h0) else $error("bits 5:3");
  a_dir_byte: assert property (
    dw && !bit_wr |-> ##2 port2_pin_oe == ~$past(wdata, 2)) else $error("dir byte");
  a_dir_bit: assert property (
    dw && bit_wr |-> ##2 port2_pin_oe[$past(bit_sel, 2)] != $past(wdata[0], 2)) else $error("dir bit");
  a_reset_dir: assert property ($rose(rst_n) |-> port2_pin_oe == 8'h00) else $error("dir reset");
  a_stop_quiet: assert property (mw && !wdata[7] |-> ##3 !match_irq) else $error("irq stopped");
  a_stop_count: assert property (
    mw && !wdata[7] ##3 rd_en && addr == EVT_ADDR_COUNT |=> rdata == 8'h00) else $error("count");
  a_ext_pin: assert property (
    mw && wdata[2] |-> ##3 port2_pin_out[7] == port2_latch[7]) else $error("ext pin");
  c_irq: cover property (match_irq);
  c_run: cover property (mw && wdata[7]);
  c_bit: cover property (dw && bit_wr);
endmodule

// ==== tb/test_eight_bit_interval_event_timer.sv ====
// self-checking bench for the interval event timer
module test_eight_bit_interval_event_timer
  import evt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, bit_wr = 1'b0;
  logic [2:0] bit_sel = 3'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, port2_latch = 8'h00;
  logic [7:0] rdata, port2_pin_in, port2_pin_out, port2_pin_oe;
  logic match_irq;
  int mismatches = 0, checked = 0, cyc = 0;
  evt_timer #(.PRESCALE(4)) u_dut (.clk, .rst_n, .addr, .wr_en, .bit_wr, .bit_sel, .wdata,
    .rd_en, .rdata, .port2_latch, .port2_pin_in, .port2_pin_out, .port2_pin_oe, .match_irq);
  evt_pin_model u_pin (.clk, .pin(port2_pin_in));
  initial forever #5 clk = ~clk;
  // the whole run needs well under 2000 cycles
  always @(posedge clk)
    if (++cyc > 5000)
    begin
      mismatches++;
      stop_test();
    end
  task automatic stop_test();
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // all drivers run 1 ns after the edge, so #10 keeps that offset
  task automatic wr(logic [15:0] a, logic [7:0] d, logic b = 1'b0, logic [2:0] s = 3'h0);
    {addr, wdata, bit_wr, bit_sel, wr_en} = {a, d, b, s, 1'b1};
    #10 wr_en = 1'b0;
    #10;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e, string n);
    {addr, rd_en} = {a, 1'b1};
    #10 rd_en = 1'b0;
    chk(n, e, rdata);
    #10;
  endtask
  task automatic gap(int e);
    int t;
    repeat (2)
    begin
      t = 0;
      do #10 t++; while (match_irq !== 1'b1 && t < 300);
    end
    chk("interval", 8'(e - 1), 8'(t - 1));
  endtask
  task automatic t_reset();
    chk("oe", 8'h00, port2_pin_oe);
    rd(EVT_ADDR_MODE_CTRL, 8'h00, "mode");
    rd(EVT_ADDR_PORT2_DIR, 8'hFF, "dir");
    rd(EVT_ADDR_COUNT, 8'h00, "count");
    rd(16'h0000, 8'h00, "unmapped");
  endtask
  task automatic t_interval(logic [1:0] s, logic [7:0] c, int e);
    wr(EVT_ADDR_MODE_CTRL, 8'h00);
    wr(EVT_ADDR_MODE_CTRL, {5'h00, s, 1'b0});
    wr(EVT_ADDR_COMPARE, c);
    wr(EVT_ADDR_MODE_CTRL, {5'h10, s, 1'b0});
    gap(e);
  endtask
  task automatic t_stop();
    wr(EVT_ADDR_MODE_CTRL, 8'h7E);
    #10 rd(EVT_ADDR_COUNT, 8'h00, "stopped count");
    rd(EVT_ADDR_MODE_CTRL, 8'h46, "mode bits");
  endtask
  task automatic t_output();
    logic [1:0] seen = 2'b00;
    wr(EVT_ADDR_PORT2_DIR, 8'hA5);
    wr(EVT_ADDR_PORT2_DIR, 8'h00, 1'b1, 3'h7);
    wr(EVT_ADDR_MODE_CTRL, 8'h01);
    wr(EVT_ADDR_MODE_CTRL, 8'h81);
    repeat (6) #10 seen[port2_pin_out[7]] = 1'b1;
    chk("toggle", 8'h03, {6'h00, seen});
    wr(EVT_ADDR_MODE_CTRL, 8'h01);
    #20 chk("pin", 8'h00, port2_pin_out);
    chk("oe", 8'hDA, port2_pin_oe);
  endtask
  task automatic t_pwm();
    wr(EVT_ADDR_MODE_CTRL, 8'h41);
    wr(EVT_ADDR_COMPARE, 8'h80);
    wr(EVT_ADDR_MODE_CTRL, 8'hC1);
    gap(256);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_interval(2'b00, 8'hFF, 256);
    t_interval(2'b01, 8'h01, 8);
    t_interval(2'b10, 8'h01, 16);
    t_interval(2'b11, 8'h01, 16);
    t_stop();
    t_output();
    t_pwm();
    stop_test();
  end
endmodule
bind evt_timer evt_timer_assertions u_chk (.clk, .rst_n, .addr, .wr_en, .bit_wr, .bit_sel,
  .wdata, .rd_en, .rdata, .port2_latch, .port2_pin_out, .port2_pin_oe, .match_irq);
